//--- logic/cgc_pkg.sv
package cgc_pkg;

  localparam int          DATA_W        = 8;

  // Global index map
  localparam logic [7:0]  IDX_CFG_CTRL  = 8'h02;
  localparam logic [7:0]  IDX_LDN_SEL   = 8'h07;
  localparam logic [7:0]  IDX_DEV_ID    = 8'h20;
  localparam logic [7:0]  IDX_DEV_REV   = 8'h21;
  localparam logic [7:0]  IDX_PWR_CTRL  = 8'h22;
  localparam logic [7:0]  IDX_AUTO_PM   = 8'h23;
  localparam logic [7:0]  IDX_GLB_LAST  = 8'h2f;
  localparam logic [7:0]  IDX_ACTIVATE  = 8'h30;

  // Field positions
  localparam int          SOFT_RST_BIT  = 0;

  // Implemented bits of each register
  localparam logic [7:0]  PWR_CTRL_MASK = 8'h7d;
  localparam logic [7:0]  AUTO_PM_MASK  = 8'h79;
  // Power-control bits held only by the standby-supply power-on reset
  localparam logic [7:0]  PWR_STBY_MASK = 8'h20;

  // Reset values
  localparam logic [7:0]  INDEX_RST     = 8'h00;
  localparam logic [7:0]  LDN_RST       = 8'h00;
  localparam logic [7:0]  PWR_CTRL_RST  = 8'h00;
  localparam logic [7:0]  AUTO_PM_RST   = 8'h00;
  localparam logic [7:0]  RD_ZERO       = 8'h00;

  // Host port select values
  localparam logic        PORT_INDEX    = 1'b0;
  localparam logic        PORT_DATA     = 1'b1;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] pwr;
    logic [7:0] apm;
    logic       softPend;
    logic [7:0] rdData;
    logic       rdValid;
    logic       actStrobe;
    logic [7:0] actDevice;
    logic [7:0] actValue;
  } cgc_state_s;

  localparam cgc_state_s STATE_RST = '{
    index:     INDEX_RST,
    ldn:       LDN_RST,
    pwr:       PWR_CTRL_RST,
    apm:       AUTO_PM_RST,
    softPend:  1'b0,
    rdData:    RD_ZERO,
    rdValid:   1'b0,
    actStrobe: 1'b0,
    actDevice: LDN_RST,
    actValue:  RD_ZERO
  };

endpackage : cgc_pkg

//--- logic/cgc_sync_if.sv
interface cgc_sync_if #(
  parameter int W = 2
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport sink   (input raw, output sync);
  modport source (output raw, input sync);
endinterface : cgc_sync_if

//--- logic/cgc_sync2.sv
module cgc_sync2 #(
  parameter int W = 2
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  cgc_sync_if.sink   port
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } cgc_sync_s;

  cgc_sync_s state_q;
  cgc_sync_s state_d;

  always_comb begin
    state_d.stage1 = port.raw;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign port.sync = state_q.stage2;

endmodule : cgc_sync2

//--- logic/cgc_global_regs.sv
// Summary of operation
// - Global bank spans indices 0x00 to 0x2F, decoded on all eight index bits.
// - Unimplemented locations and bits drop writes and read back as zero.
// - Reserved indices 0x00-0x01, 0x03-0x06, 0x08-0x1F are read-only zero.
// - Host writes index port first; data port then reaches the chosen register.
// - Index and data accesses are ignored unless configuration mode is active.
// - Writing one to bit 0 at 0x02 soft-resets; the bit clears itself.
// - Writing index 0x07 picks the logical device for later per-device accesses.
// - Activate writes go only to the currently selected logical device.
// - Index 0x20 returns a fixed identification byte, untouched by reset or write.
// - Index 0x21 returns the fixed silicon revision byte.
// - Index 0x22 holds one power bit per function; bits 1 and 7 reserved.
// - Index 0x23 enables automatic power management per function; bits 1, 2 and 7 read zero.
// - Power bit 5 clears only on standby-supply power-on reset.
module cgc_global_regs #(
  parameter logic [7:0] DEV_ID_VALUE  = 8'ha5,  // Arbitrary identification value
  parameter logic [7:0] DEV_REV_VALUE = 8'h01   // Arbitrary revision value
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        mainPorPin,
  input  wire logic                        hardRstPin,
  input  wire logic                        configMode,
  input  wire logic                        hostWrite,
  input  wire logic                        hostRead,
  input  wire logic                        hostPortSel,
  input  wire logic [cgc_pkg::DATA_W-1:0]  hostWrData,
  output logic      [cgc_pkg::DATA_W-1:0]  hostRdData,
  output logic                             hostRdValid,
  output logic      [cgc_pkg::DATA_W-1:0]  logicalDevice,
  output logic      [cgc_pkg::DATA_W-1:0]  funcPowerOn,
  output logic      [cgc_pkg::DATA_W-1:0]  funcAutoPm,
  output logic                             activateStrobe,
  output logic      [cgc_pkg::DATA_W-1:0]  activateDevice,
  output logic      [cgc_pkg::DATA_W-1:0]  activateValue,
  output logic                             softResetActive
);
  import cgc_pkg::*;

  cgc_state_s state_q;
  cgc_state_s state_d;

  // Main-supply power-on and hard reset arrive from pins
  cgc_sync_if #(.W(2)) rstIf ();

  assign rstIf.raw = {hardRstPin, mainPorPin};

  cgc_sync2 #(
    .W (2)
  ) u_rst_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .port    (rstIf.sink)
  );

  logic mainPorSync;
  logic hardRstSync;
  logic pinReset;

  assign mainPorSync = rstIf.sync[0];
  assign hardRstSync = rstIf.sync[1];
  assign pinReset    = mainPorSync | hardRstSync;

  // Host access qualification
  logic cfgWrite;
  logic cfgRead;
  logic idxWrite;
  logic idxRead;
  logic datWrite;
  logic datRead;

  always_comb begin
    cfgWrite = hostWrite & configMode;
    cfgRead  = hostRead  & configMode;
    idxWrite = cfgWrite & (hostPortSel == PORT_INDEX);
    idxRead  = cfgRead  & (hostPortSel == PORT_INDEX);
    datWrite = cfgWrite & (hostPortSel == PORT_DATA);
    datRead  = cfgRead  & (hostPortSel == PORT_DATA);
  end

  // Full eight-bit decode of the selected index
  logic selCfgCtrl;
  logic selLdn;
  logic selDevId;
  logic selDevRev;
  logic selPwr;
  logic selApm;
  logic selActivate;

  always_comb begin
    selCfgCtrl  = (state_q.index == IDX_CFG_CTRL);
    selLdn      = (state_q.index == IDX_LDN_SEL);
    selDevId    = (state_q.index == IDX_DEV_ID);
    selDevRev   = (state_q.index == IDX_DEV_REV);
    selPwr      = (state_q.index == IDX_PWR_CTRL);
    selApm      = (state_q.index == IDX_AUTO_PM);
    selActivate = (state_q.index == IDX_ACTIVATE);
  end

  // Read multiplexer for the data port
  logic [7:0] dataReadValue;

  always_comb begin
    dataReadValue = RD_ZERO;
    if (state_q.index <= IDX_GLB_LAST) begin
      case (state_q.index)
        IDX_LDN_SEL:  dataReadValue = state_q.ldn;
        IDX_DEV_ID:   dataReadValue = DEV_ID_VALUE;
        IDX_DEV_REV:  dataReadValue = DEV_REV_VALUE;
        IDX_PWR_CTRL: dataReadValue = state_q.pwr & PWR_CTRL_MASK;
        IDX_AUTO_PM:  dataReadValue = state_q.apm & AUTO_PM_MASK;
        default:      dataReadValue = RD_ZERO;
      endcase
    end
  end

  always_comb begin
    state_d           = state_q;
    state_d.rdValid   = 1'b0;
    state_d.actStrobe = 1'b0;
    state_d.softPend  = 1'b0;

    // Index port selects the register for later data accesses
    if (idxWrite) begin
      state_d.index = hostWrData;
    end

    if (idxRead) begin
      state_d.rdData  = state_q.index;
      state_d.rdValid = 1'b1;
    end else if (datRead) begin
      state_d.rdData  = dataReadValue;
      state_d.rdValid = 1'b1;
    end

    if (datWrite) begin
      if (selCfgCtrl && hostWrData[SOFT_RST_BIT]) begin
        state_d.softPend = 1'b1;
      end
      if (selLdn) begin
        state_d.ldn = hostWrData;
      end
      if (selPwr) begin
        state_d.pwr = hostWrData & PWR_CTRL_MASK;
      end
      if (selApm) begin
        state_d.apm = hostWrData & AUTO_PM_MASK;
      end
      if (selActivate) begin
        state_d.actStrobe = 1'b1;
        state_d.actDevice = state_q.ldn;
        state_d.actValue  = hostWrData;
      end
    end

    // Soft reset takes effect the cycle after the command and wins over a write
    if (state_q.softPend) begin
      state_d.ldn = LDN_RST;
      state_d.pwr = (PWR_CTRL_RST & ~PWR_STBY_MASK)
                  | (state_q.pwr & PWR_STBY_MASK);
    end

    // Main-supply power-on and hard reset, both synchronised
    if (pinReset) begin
      state_d       = STATE_RST;
      state_d.pwr   = (PWR_CTRL_RST & ~PWR_STBY_MASK)
                    | (state_q.pwr & PWR_STBY_MASK);
      state_d.apm   = AUTO_PM_RST;
    end
  end

  // Asynchronous reset is the standby-supply power-on reset and clears all
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign hostRdData      = state_q.rdData;
  assign hostRdValid     = state_q.rdValid;
  assign logicalDevice   = state_q.ldn;
  assign funcPowerOn     = state_q.pwr;
  assign funcAutoPm      = state_q.apm;
  assign activateStrobe  = state_q.actStrobe;
  assign activateDevice  = state_q.actDevice;
  assign activateValue   = state_q.actValue;
  assign softResetActive = state_q.softPend;

endmodule : cgc_global_regs

//--- verification/cgc_global_regs_sva.sv
module cgc_global_regs_sva (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic                       mainPorPin,
  input wire logic                       hardRstPin,
  input wire logic                       configMode,
  input wire logic                       hostWrite,
  input wire logic                       hostRead,
  input wire logic                       hostPortSel,
  input wire logic                       hostRdValid,
  input wire logic [cgc_pkg::DATA_W-1:0] logicalDevice,
  input wire logic [cgc_pkg::DATA_W-1:0] funcPowerOn,
  input wire logic [cgc_pkg::DATA_W-1:0] funcAutoPm,
  input wire logic                       activateStrobe,
  input wire logic                       softResetActive
);
  timeunit 1ns;
  timeprecision 1ps;
  import cgc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sSoftDone;
    softResetActive ##1 (!softResetActive && logicalDevice == 8'h00
      && (funcPowerOn & ~PWR_STBY_MASK) == 8'h00);
  endsequence
  a_read_answer: assert property (disable iff (sys_rst || mainPorPin || hardRstPin)
    hostRead && configMode |=> hostRdValid) else $error("read got no valid");
  a_read_quiet: assert property (!(hostRead && configMode) |=> !hostRdValid)
    else $error("valid without read");
  a_act_quiet: assert property (!(hostWrite && configMode) |=> !activateStrobe)
    else $error("activate without write");
  a_act_cause: assert property (activateStrobe |->
    $past(hostWrite && configMode && hostPortSel == PORT_DATA)) else $error("bad activate");
  a_pwr_reserved: assert property ((funcPowerOn & ~PWR_CTRL_MASK) == 8'h00)
    else $error("power reserved bit set");
  a_pm_reserved: assert property ((funcAutoPm & ~AUTO_PM_MASK) == 8'h00)
    else $error("pm reserved bit set");
  a_soft_clear: assert property (softResetActive |-> sSoftDone)
    else $error("soft reset incomplete");
  a_soft_keep: assert property (softResetActive |=>
    funcPowerOn[5] == $past(funcPowerOn[5])) else $error("standby bit lost");
endmodule // cgc_global_regs_sva

bind cgc_global_regs cgc_global_regs_sva u_sva (.*);

//--- verification/cgc_host_model.sv
module cgc_host_model (
  input  wire logic                       clk,
  output logic                            hostWrite,
  output logic                            hostRead,
  output logic                            hostPortSel,
  output logic [cgc_pkg::DATA_W-1:0]      hostWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  import cgc_pkg::*;
  initial begin
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostPortSel = PORT_INDEX;
    hostWrData = 8'h00;
  end
  // One-cycle strobe; each call makes a single access to either the index or the data port
  task automatic acc(input logic w, input logic s, input logic [DATA_W-1:0] d);
    @(posedge clk);
    hostWrite <= w;
    hostRead <= !w;
    hostPortSel <= s;
    hostWrData <= d;
    @(posedge clk);
    hostWrite <= 1'b0;
    hostRead <= 1'b0;
  endtask
endmodule // cgc_host_model

//--- verification/chip_global_config_regs_tb.sv
module chip_global_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cgc_pkg::*;
  localparam logic [7:0] ID  = 8'h3c;  // Arbitrary
  localparam logic [7:0] REV = 8'h02;  // Arbitrary
  logic       clk, sys_rst, mainPorPin, hardRstPin, configMode;
  logic       hostWrite, hostRead, hostPortSel, hostRdValid, activateStrobe, softResetActive;
  logic [7:0] hostWrData, hostRdData, logicalDevice, funcPowerOn, funcAutoPm;
  logic [7:0] activateDevice, activateValue;
  int         mismatches, checks_done;
  cgc_host_model host (.clk(clk), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostPortSel(hostPortSel), .hostWrData(hostWrData));
  cgc_global_regs #(.DEV_ID_VALUE(ID), .DEV_REV_VALUE(REV)) DUT (.clk(clk), .sys_rst(sys_rst),
    .mainPorPin(mainPorPin), .hardRstPin(hardRstPin), .configMode(configMode),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostPortSel(hostPortSel),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .logicalDevice(logicalDevice), .funcPowerOn(funcPowerOn), .funcAutoPm(funcAutoPm),
    .activateStrobe(activateStrobe), .activateDevice(activateDevice),
    .activateValue(activateValue), .softResetActive(softResetActive));
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host.acc(1'b1, PORT_INDEX, i);
    host.acc(1'b1, PORT_DATA, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    host.acc(1'b1, PORT_INDEX, i);
    host.acc(1'b0, PORT_DATA, 8'h00);
    #1 chk($sformatf("index %h", i), {15'h0, hostRdValid, hostRdData}, {15'h0, 1'b1, e});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    {sys_rst, mainPorPin, hardRstPin, configMode} = 4'b1001;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IDX_DEV_ID, ID);
    rd(IDX_DEV_REV, REV);
    rd(IDX_LDN_SEL, 8'h00);
    $display("identity test done");
    for (int i = 0; i < 8'h30; i++) begin
      if (!(i inside {7, 8'h20, 8'h21, 8'h22, 8'h23})) begin
        wr(i[7:0], 8'hff);
        rd(i[7:0], 8'h00);
      end
    end
    wr(8'ha2, 8'hff);
    host.acc(1'b0, PORT_INDEX, 8'h00);
    #1 chk("index port", {15'h0, hostRdValid, hostRdData}, {15'h0, 1'b1, 8'ha2});
    rd(IDX_PWR_CTRL, 8'h00);
    rd(IDX_DEV_ID, ID);
    $display("reserved test done");
    wr(IDX_PWR_CTRL, 8'hff);
    rd(IDX_PWR_CTRL, 8'h7d);
    chk("power", {16'h0, funcPowerOn}, 24'h00007d);
    wr(IDX_AUTO_PM, 8'hff);
    rd(IDX_AUTO_PM, 8'h79);
    wr(IDX_LDN_SEL, 8'h05);
    rd(IDX_LDN_SEL, 8'h05);
    wr(IDX_ACTIVATE, 8'ha1);
    #1 chk("activate", {7'h0, activateStrobe, activateDevice, activateValue},
      {7'h0, 1'b1, 8'h05, 8'ha1});
    chk("activate selector", {16'h0, logicalDevice}, 24'h000005);
    $display("power test done");
    wr(IDX_CFG_CTRL, 8'h01);
    #1 chk("soft", {23'h0, softResetActive}, 24'h000001);
    @(posedge clk);
    #1 chk("after soft", {logicalDevice, funcPowerOn, funcAutoPm}, 24'h002079);
    rd(IDX_CFG_CTRL, 8'h00);
    $display("soft reset test done");
    wr(IDX_LDN_SEL, 8'h05);
    @(posedge clk) configMode <= 1'b0;
    wr(IDX_LDN_SEL, 8'h09);
    host.acc(1'b0, PORT_DATA, 8'h00);
    #1 chk("mode off", {15'h0, hostRdValid, logicalDevice}, 24'h000005);
    @(posedge clk) configMode <= 1'b1;
    rd(IDX_LDN_SEL, 8'h05);
    $display("mode test done");
    for (int p = 0; p < 2; p++) begin
      wr(IDX_PWR_CTRL, 8'hff);
      wr(IDX_AUTO_PM, 8'hff);
      @(posedge clk) {mainPorPin, hardRstPin} <= p ? 2'b10 : 2'b01;
      repeat (4) @(posedge clk);
      {mainPorPin, hardRstPin} <= 2'b00;
      repeat (4) @(posedge clk);
      #1 chk("pin", {logicalDevice, funcPowerOn, funcAutoPm}, 24'h002000);
    end
    @(posedge clk) sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    #1 chk("standby", {16'h0, funcPowerOn}, 24'h000000);
    $display("reset test done");
    summarize();
  end
endmodule // chip_global_config_regs_tb
